// ### hdl/card_transfer_flags.sv
// card transfer flags: request bits, busy/done/error flags, result code, engine handshake
//
// Overview of operation
// - download request starts card-to-controller image transfer
// - upload request writes controller image to card
// - download busy set at start, cleared at end
// - upload busy set at start, cleared at end
// - done cleared at start, set at finish
// - error bit updated only when transfer finishes or an upload is refused
// - error cleared when the engine finishes without a fault, whether or not anything moved
// - error set when transfer reports a fault
// - requests read/write; busy, done, error read-only
// - completion code recorded, zero means normal
// - upload refused while controller read protected
module card_transfer_flags #(
   parameter int TIMEOUT_LIMIT = card_xfer_pkg::TIMEOUT_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register port
   input wire card_xfer_pkg::reg_req_t reg_req,
   output logic [31:0] reg_rdata,
   // card transfer engine
   output card_xfer_pkg::engine_req_t engine_req,
   input wire card_xfer_pkg::engine_rsp_t engine_rsp,
   // controller state
   input wire logic read_protected,
   // interrupt
   output logic irq
);
   initial begin
      if (TIMEOUT_LIMIT < 2) $error("card_transfer_flags: TIMEOUT_LIMIT too small");
   end

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_RUN
   } xfer_state_t;

   xfer_state_t state;
   logic download_request_bit;
   logic upload_request_bit;
   logic download_busy_bit;
   logic upload_busy_bit;
   logic transfer_done_bit;
   logic transfer_error_bit;
   logic [7:0] transfer_result_code;
   card_xfer_pkg::xfer_dir_t dir;
   logic timed_out;
   logic ctl_write;
   logic go_download;
   logic go_upload;
   logic refuse_upload;
   logic finishing;
   logic [card_xfer_pkg::IRQ_WIDTH-1:0] irq_events;
   logic [card_xfer_pkg::IRQ_WIDTH-1:0] irq_stat;
   logic [card_xfer_pkg::IRQ_WIDTH-1:0] irq_mask;

   function automatic logic addr_is(input logic [3:0] a, input logic [3:0] r);
      return a == r;
   endfunction

   assign ctl_write = reg_req.wr && addr_is(reg_req.addr, card_xfer_pkg::REG_CONTROL);

   // -----------------------------------------------------------------
   // request bits
   // -----------------------------------------------------------------
   // a request bit is consumed when its transfer is launched or refused,
   // so it reads back high only while waiting for the block to act
   always_ff @(posedge core_clk) begin
      if (srst) begin
         download_request_bit <= card_xfer_pkg::CONTROL_RESET[card_xfer_pkg::CTL_DOWNLOAD_POS];
      end else if (ctl_write) begin
         download_request_bit <= reg_req.wdata[card_xfer_pkg::CTL_DOWNLOAD_POS];
      end else if (go_download) begin
         download_request_bit <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         upload_request_bit <= card_xfer_pkg::CONTROL_RESET[card_xfer_pkg::CTL_UPLOAD_POS];
      end else if (ctl_write) begin
         upload_request_bit <= reg_req.wdata[card_xfer_pkg::CTL_UPLOAD_POS];
      end else if (go_upload || refuse_upload) begin
         upload_request_bit <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // launch decision
   // -----------------------------------------------------------------
   // download has priority when both are pending; requests only act in idle,
   // so writes during a transfer just stay pending as stored bits
   always_comb begin
      go_download = (state == ST_IDLE) && download_request_bit;
      refuse_upload = (state == ST_IDLE) && !download_request_bit && upload_request_bit
                      && read_protected;
      go_upload = (state == ST_IDLE) && !download_request_bit && upload_request_bit
                  && !read_protected;
   end

   assign finishing = (state == ST_RUN) && (engine_rsp.finish || timed_out);

   // -----------------------------------------------------------------
   // transfer sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= ST_IDLE;
         dir <= card_xfer_pkg::DIR_DOWNLOAD;
      end else begin
         case (state)
            ST_IDLE: begin
               if (go_download) begin
                  state <= ST_START;
                  dir <= card_xfer_pkg::DIR_DOWNLOAD;
               end else if (go_upload) begin
                  state <= ST_START;
                  dir <= card_xfer_pkg::DIR_UPLOAD;
               end
            end
            ST_START: state <= ST_RUN;
            ST_RUN: begin
               if (finishing) state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // one-cycle start pulse to the engine, registered
   always_ff @(posedge core_clk) begin
      if (srst) begin
         engine_req <= '0;
      end else begin
         engine_req.start <= go_download || go_upload;
         engine_req.dir <= go_upload ? card_xfer_pkg::DIR_UPLOAD : card_xfer_pkg::DIR_DOWNLOAD;
      end
   end

   xfer_timeout #(
      .LIMIT(TIMEOUT_LIMIT)
   ) u_timeout (
      .core_clk(core_clk),
      .srst(srst),
      .run(state == ST_RUN),
      .expired(timed_out)
   );

   // -----------------------------------------------------------------
   // busy and done flags
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         download_busy_bit <= 1'b0;
      end else if (go_download) begin
         download_busy_bit <= 1'b1;
      end else if (finishing && dir == card_xfer_pkg::DIR_DOWNLOAD) begin
         download_busy_bit <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         upload_busy_bit <= 1'b0;
      end else if (go_upload) begin
         upload_busy_bit <= 1'b1;
      end else if (finishing && dir == card_xfer_pkg::DIR_UPLOAD) begin
         upload_busy_bit <= 1'b0;
      end
   end

   // a refused upload also completes at once so software sees an outcome
   always_ff @(posedge core_clk) begin
      if (srst) begin
         transfer_done_bit <= 1'b0;
      end else if (go_download || go_upload) begin
         transfer_done_bit <= 1'b0;
      end else if (finishing || refuse_upload) begin
         transfer_done_bit <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // error flag and completion code
   // -----------------------------------------------------------------
   // a timeout counts as a fault; the engine's own code wins otherwise
   always_ff @(posedge core_clk) begin
      if (srst) begin
         transfer_error_bit <= 1'b0;
      end else if (refuse_upload) begin
         transfer_error_bit <= 1'b1;
      end else if (finishing) begin
         if (timed_out && !engine_rsp.finish) transfer_error_bit <= 1'b1;
         else if (engine_rsp.fault) transfer_error_bit <= 1'b1;
         else transfer_error_bit <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         transfer_result_code <= card_xfer_pkg::RESULT_RESET;
      end else if (refuse_upload) begin
         transfer_result_code <= card_xfer_pkg::RESULT_PROTECTED;
      end else if (finishing) begin
         if (!engine_rsp.finish) transfer_result_code <= 8'hFF;
         else if (!engine_rsp.fault && engine_rsp.moved) transfer_result_code <= card_xfer_pkg::RESULT_NORMAL;
         else transfer_result_code <= engine_rsp.code;
      end
   end

   // -----------------------------------------------------------------
   // interrupts
   // -----------------------------------------------------------------
   always_comb begin
      irq_events = '0;
      irq_events[card_xfer_pkg::IRQ_DONE_POS] = finishing;
      irq_events[card_xfer_pkg::IRQ_ERROR_POS] = (finishing && (engine_rsp.fault || !engine_rsp.finish));
      irq_events[card_xfer_pkg::IRQ_REFUSED_POS] = refuse_upload;
   end

   irq_status #(
      .WIDTH(card_xfer_pkg::IRQ_WIDTH)
   ) u_irq (
      .core_clk(core_clk),
      .srst(srst),
      .event_set(irq_events),
      .read_clear(reg_req.rd && addr_is(reg_req.addr, card_xfer_pkg::REG_IRQ_STATUS)),
      .mask_write(reg_req.wr && addr_is(reg_req.addr, card_xfer_pkg::REG_IRQ_MASK)),
      .mask_wdata(reg_req.wdata[card_xfer_pkg::IRQ_WIDTH-1:0]),
      .status(irq_stat),
      .mask(irq_mask),
      .irq(irq)
   );

   // -----------------------------------------------------------------
   // read port
   // -----------------------------------------------------------------
   // writes to status, result and unmapped words are dropped; unmapped reads give zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_req.rd) begin
         reg_rdata <= 32'h0000_0000;
         case (reg_req.addr)
            card_xfer_pkg::REG_CONTROL: begin
               reg_rdata[card_xfer_pkg::CTL_DOWNLOAD_POS] <= download_request_bit;
               reg_rdata[card_xfer_pkg::CTL_UPLOAD_POS] <= upload_request_bit;
            end
            card_xfer_pkg::REG_STATUS: begin
               reg_rdata[card_xfer_pkg::STS_DOWNLOAD_BUSY_POS] <= download_busy_bit;
               reg_rdata[card_xfer_pkg::STS_UPLOAD_BUSY_POS] <= upload_busy_bit;
               reg_rdata[card_xfer_pkg::STS_DONE_POS] <= transfer_done_bit;
               reg_rdata[card_xfer_pkg::STS_ERROR_POS] <= transfer_error_bit;
               reg_rdata[card_xfer_pkg::STS_PROTECTED_POS] <= read_protected;
            end
            card_xfer_pkg::REG_RESULT: reg_rdata[7:0] <= transfer_result_code;
            card_xfer_pkg::REG_IRQ_STATUS: reg_rdata[card_xfer_pkg::IRQ_WIDTH-1:0] <= irq_stat;
            card_xfer_pkg::REG_IRQ_MASK: reg_rdata[card_xfer_pkg::IRQ_WIDTH-1:0] <= irq_mask;
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule // card_transfer_flags

// ### hdl/card_xfer_pkg.sv
// package: register map, fields, codes and timing for the card transfer flag block
package card_xfer_pkg;

   // register indices on the plain register port (byte address = index * 4 not used; port is word addressed)
   localparam logic [3:0] REG_CONTROL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_RESULT = 4'h2;
   localparam logic [3:0] REG_IRQ_STATUS = 4'h3;
   localparam logic [3:0] REG_IRQ_MASK = 4'h4;

   // control field positions
   localparam int CTL_DOWNLOAD_POS = 0;
   localparam int CTL_UPLOAD_POS = 1;
   // status field positions
   localparam int STS_DOWNLOAD_BUSY_POS = 0;
   localparam int STS_UPLOAD_BUSY_POS = 1;
   localparam int STS_DONE_POS = 2;
   localparam int STS_ERROR_POS = 3;
   localparam int STS_PROTECTED_POS = 4;
   // interrupt field positions
   localparam int IRQ_DONE_POS = 0;
   localparam int IRQ_ERROR_POS = 1;
   localparam int IRQ_REFUSED_POS = 2;
   localparam int IRQ_WIDTH = 3;

   // reset values
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   localparam logic [7:0] RESULT_RESET = 8'h00;

   // completion codes
   localparam logic [7:0] RESULT_NORMAL = 8'h00;
   localparam logic [7:0] RESULT_PROTECTED = 8'h0A;

   // engine handshake timeout
   localparam int CLOCK_MHZ = 100;
   localparam int TIMEOUT_US = 1000;
   localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLOCK_MHZ;

   typedef enum logic [0:0] {
      DIR_DOWNLOAD,
      DIR_UPLOAD
   } xfer_dir_t;

   // request from this block to the card transfer engine
   typedef struct packed {
      logic start;
      xfer_dir_t dir;
   } engine_req_t;

   // report from the engine when a transfer ends
   typedef struct packed {
      logic finish;
      logic moved;
      logic fault;
      logic [7:0] code;
   } engine_rsp_t;

   // register port
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage

// ### hdl/irq_status.sv
// sticky interrupt bits with mask, cleared by a read, set wins over clear
module irq_status #(
   parameter int WIDTH = card_xfer_pkg::IRQ_WIDTH
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // events and software access
   input wire logic [WIDTH-1:0] event_set,
   input wire logic read_clear,
   input wire logic mask_write,
   input wire logic [WIDTH-1:0] mask_wdata,
   // state
   output logic [WIDTH-1:0] status,
   output logic [WIDTH-1:0] mask,
   output logic irq
);
   initial begin
      if (WIDTH < 1) $error("irq_status: WIDTH must be positive");
   end

   always_ff @(posedge core_clk) begin
      if (srst) status <= '0;
      else status <= (read_clear ? '0 : status) | event_set;
   end

   always_ff @(posedge core_clk) begin
      if (srst) mask <= WIDTH'(card_xfer_pkg::IRQ_MASK_RESET);
      else if (mask_write) mask <= mask_wdata;
   end

   assign irq = |(status & mask);
endmodule // irq_status

// ### hdl/xfer_timeout.sv
// cycle counter that flags an engine which never reports completion
module xfer_timeout #(
   parameter int LIMIT = card_xfer_pkg::TIMEOUT_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // control
   input wire logic run,
   output logic expired
);
   initial begin
      if (LIMIT < 2) $error("xfer_timeout: LIMIT must be at least 2");
   end

   logic [$clog2(LIMIT+1)-1:0] count;

   always_ff @(posedge core_clk) begin
      if (srst || !run) begin
         count <= '0;
         expired <= 1'b0;
      end else if (count == ($clog2(LIMIT+1))'(LIMIT - 1)) begin
         expired <= 1'b1;
      end else begin
         count <= count + 1'b1;
      end
   end
endmodule // xfer_timeout

// ### sim/card_engine_model.sv
// behavioural card engine: answers each start with a finish after a set delay
module card_engine_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // block side
   input wire card_xfer_pkg::engine_req_t engine_req,
   output card_xfer_pkg::engine_rsp_t engine_rsp,
   // outcome chosen by the bench
   input wire logic [7:0] delay,
   input wire logic moved,
   input wire logic fault,
   input wire logic [7:0] code
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] left;
   logic active;
   // report fields flip every cycle outside finish so nothing stale looks valid
   always @(posedge core_clk) begin
      engine_rsp <= {1'b0, ~engine_rsp.moved, ~engine_rsp.fault, ~engine_rsp.code};
      if (srst) begin
         active <= 1'b0;
         engine_rsp <= '0;
      end else if (engine_req.start) begin
         active <= 1'b1;
         left <= delay;
      end else if (active && left != 8'h00) left <= left - 8'h01;
      else if (active) begin
         active <= 1'b0;
         engine_rsp <= {1'b1, moved, fault, code};
      end
   end
endmodule // card_engine_model

// ### sim/card_xfer_checker.sv
// checker: port-level assertions for the card transfer flag block
module card_xfer_checker #(
   parameter int TIMEOUT_LIMIT = 20
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // watched ports
   input wire card_xfer_pkg::reg_req_t reg_req,
   input wire logic [31:0] reg_rdata,
   input wire card_xfer_pkg::engine_req_t engine_req,
   input wire card_xfer_pkg::engine_rsp_t engine_rsp,
   input wire logic read_protected,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic running;
   logic [2:0] mask;
   logic ctl_wr;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // ----
   // tracking
   // ----
   // a timed-out transfer keeps running high until the engine's late finish;
   // the bench keeps the done mask clear and starts nothing new in that window
   always_ff @(posedge core_clk) begin
      if (srst) running <= 1'b0;
      else if (engine_req.start) running <= 1'b1;
      else if (engine_rsp.finish) running <= 1'b0;
   end
   always_ff @(posedge core_clk) begin
      if (srst) mask <= 3'h0;
      else if (reg_req.wr && reg_req.addr == card_xfer_pkg::REG_IRQ_MASK) mask <= reg_req.wdata[2:0];
   end
   assign ctl_wr = reg_req.wr && reg_req.addr == card_xfer_pkg::REG_CONTROL && !running && !engine_req.start;
   // ----
   // properties
   // ----
   property p_rdata_idle;
      !$past(reg_req.rd) |-> reg_rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
   property p_start_pulse;
      engine_req.start |=> !engine_req.start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
   property p_dl_launch;
      ctl_wr && reg_req.wdata[0] |-> ##2 engine_req.start && engine_req.dir == card_xfer_pkg::DIR_DOWNLOAD;
   endproperty
   a_dl_launch: assert property (p_dl_launch) else $error("download not launched");
   property p_ul_launch;
      ctl_wr && reg_req.wdata[1:0] == 2'h2 && !read_protected |->
         ##2 engine_req.start && engine_req.dir == card_xfer_pkg::DIR_UPLOAD;
   endproperty
   a_ul_launch: assert property (p_ul_launch) else $error("upload not launched");
   property p_ul_refused;
      ctl_wr && reg_req.wdata[1:0] == 2'h2 && read_protected |-> ##1 !engine_req.start [*4];
   endproperty
   a_ul_refused: assert property (p_ul_refused) else $error("protected upload launched");
   property p_one_at_a_time;
      running && !engine_rsp.finish |=> !engine_req.start;
   endproperty
   a_one_at_a_time: assert property (p_one_at_a_time) else $error("start while busy");
   property p_done_irq;
      running && engine_rsp.finish && mask[card_xfer_pkg::IRQ_DONE_POS] |=> irq;
   endproperty
   a_done_irq: assert property (p_done_irq) else $error("no interrupt on completion");
   property p_irq_masked;
      mask == 3'h0 |-> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("interrupt while fully masked");
endmodule // card_xfer_checker

bind card_transfer_flags card_xfer_checker #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) u_card_xfer_checker (
   .core_clk(core_clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata), .engine_req(engine_req),
   .engine_rsp(engine_rsp), .read_protected(read_protected), .irq(irq));

// ### sim/tb_card_transfer_flags.sv
// testbench for the card transfer flag block
module tb_card_transfer_flags;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic dir;
      logic moved;
      logic fault;
      logic [7:0] code;
      logic [3:0] status;
      logic [7:0] result;
      logic [2:0] irqs;
   } row_t;
   logic core_clk;
   logic srst;
   card_xfer_pkg::reg_req_t reg_req;
   logic [31:0] reg_rdata;
   card_xfer_pkg::engine_req_t engine_req;
   card_xfer_pkg::engine_rsp_t engine_rsp;
   logic read_protected;
   logic irq;
   logic [7:0] delay;
   logic moved;
   logic fault;
   logic [7:0] code;
   row_t rows [5];
   logic [31:0] v;
   logic err_prev;
   int fails = 0;
   int n_checks = 0;
   card_transfer_flags #(.TIMEOUT_LIMIT(20)) u_card_transfer_flags (.core_clk(core_clk), .srst(srst),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .engine_req(engine_req), .engine_rsp(engine_rsp),
      .read_protected(read_protected), .irq(irq));
   card_engine_model u_card_engine_model (.core_clk(core_clk), .srst(srst), .engine_req(engine_req),
      .engine_rsp(engine_rsp), .delay(delay), .moved(moved), .fault(fault), .code(code));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ----
   // tasks
   // ----
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic reset_dut();
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      reg_req.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      reg_req.rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_start(output logic [31:0] got);
      got = 32'h0000_0000;
      for (int k = 0; k < 40 && got == 32'h0000_0000; k++) begin
         @(posedge core_clk);
         #1 got = {30'h0, engine_req.start, engine_req.start & engine_req.dir};
      end
   endtask
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      complete_run();
   end
   // ----
   // sequence
   // ----
   initial begin
      srst = 1'b1;
      reg_req = '0;
      read_protected = 1'b0;
      delay = 8'h08;
      moved = 1'b0;
      fault = 1'b0;
      code = 8'h00;
      err_prev = 1'b0;
      rows[0] = {1'b0, 1'b1, 1'b0, 8'h00, 4'h4, 8'h00, 3'h1};
      rows[1] = {1'b1, 1'b1, 1'b0, 8'h00, 4'h4, 8'h00, 3'h1};
      rows[2] = {1'b0, 1'b1, 1'b1, 8'h07, 4'hc, 8'h07, 3'h3};
      rows[3] = {1'b1, 1'b0, 1'b1, 8'h04, 4'hc, 8'h04, 3'h3};
      rows[4] = {1'b0, 1'b0, 1'b0, 8'h05, 4'h4, 8'h05, 3'h1};
      reset_dut();
      reg_write(card_xfer_pkg::REG_IRQ_MASK, 32'h0000_0007);
      foreach (rows[i]) begin
         moved <= rows[i].moved;
         fault <= rows[i].fault;
         code <= rows[i].code;
         reg_write(card_xfer_pkg::REG_CONTROL, {30'h0, rows[i].dir, ~rows[i].dir});
         // the request bit lands on the write edge, the registered start one edge later
         @(posedge core_clk);
         #1 chk("start", {30'h0, engine_req.start, engine_req.start & engine_req.dir},
            {30'h0, 1'b1, rows[i].dir});
         reg_read(card_xfer_pkg::REG_STATUS, v);
         chk("busy", v, {28'h0, err_prev, 1'b0, rows[i].dir, ~rows[i].dir});
         repeat (12) @(posedge core_clk);
         #1 chk("irq", {31'h0, irq}, 32'h0000_0001);
         reg_read(card_xfer_pkg::REG_STATUS, v);
         chk("status", v, {28'h0, rows[i].status});
         reg_read(card_xfer_pkg::REG_RESULT, v);
         chk("result", v, {24'h0, rows[i].result});
         reg_read(card_xfer_pkg::REG_IRQ_STATUS, v);
         chk("irq status", v, {29'h0, rows[i].irqs});
         #1 chk("irq clear", {31'h0, irq}, 32'h0000_0000);
         err_prev = rows[i].status[3];
      end
      $display("table cases done");
      moved <= 1'b1;
      fault <= 1'b0;
      reg_write(card_xfer_pkg::REG_CONTROL, 32'h0000_0001);
      reg_write(card_xfer_pkg::REG_CONTROL, 32'h0000_0002);
      reg_read(card_xfer_pkg::REG_CONTROL, v);
      chk("pending", v, 32'h0000_0002);
      wait_start(v);
      chk("queued start", v, 32'h0000_0003);
      repeat (12) @(posedge core_clk);
      reg_write(card_xfer_pkg::REG_STATUS, 32'hffff_ffff);
      reg_write(card_xfer_pkg::REG_RESULT, 32'hffff_ffff);
      reg_read(card_xfer_pkg::REG_STATUS, v);
      chk("ro status", v, 32'h0000_0004);
      reg_read(card_xfer_pkg::REG_RESULT, v);
      chk("ro result", v, 32'h0000_0000);
      reg_read(4'hf, v);
      chk("unmapped", v, 32'h0000_0000);
      $display("queue and access cases done");
      reset_dut();
      for (int a = 0; a < 5; a++) begin
         reg_read(4'(a), v);
         chk("reset value", v, 32'h0000_0000);
      end
      @(posedge core_clk);
      read_protected <= 1'b1;
      reg_write(card_xfer_pkg::REG_CONTROL, 32'h0000_0002);
      repeat (4) @(posedge core_clk);
      reg_read(card_xfer_pkg::REG_STATUS, v);
      chk("refused status", v, 32'h0000_001c);
      reg_read(card_xfer_pkg::REG_RESULT, v);
      chk("refused code", v, 32'h0000_000a);
      chk("masked irq", {31'h0, irq}, 32'h0000_0000);
      reg_write(card_xfer_pkg::REG_IRQ_MASK, 32'h0000_0004);
      #1 chk("refused irq", {31'h0, irq}, 32'h0000_0001);
      reg_read(card_xfer_pkg::REG_IRQ_STATUS, v);
      chk("refused irq bit", v & 32'h0000_0004, 32'h0000_0004);
      @(posedge core_clk);
      read_protected <= 1'b0;
      $display("refused upload case done");
      reg_write(card_xfer_pkg::REG_CONTROL, 32'h0000_0001);
      repeat (3) @(posedge core_clk);
      reset_dut();
      reg_read(card_xfer_pkg::REG_STATUS, v);
      chk("reset mid run", v, 32'h0000_0000);
      $display("reset cases done");
      // engine answers far too late: the block must give up on its own
      delay <= 8'hff;
      reg_write(card_xfer_pkg::REG_CONTROL, 32'h0000_0001);
      repeat (30) @(posedge core_clk);
      reg_read(card_xfer_pkg::REG_STATUS, v);
      chk("timeout status", v, 32'h0000_000c);
      reg_read(card_xfer_pkg::REG_RESULT, v);
      chk("timeout code", v, 32'h0000_00ff);
      $display("timeout case done");
      complete_run();
   end
endmodule // tb_card_transfer_flags
